// File: hdl/disk_port_pkg.sv
// Purpose: shared constants and types for the disk port data path
// Assumes: both ends run on one clock, i_clk at 100 MHz
// Notes:   host register map is local to the host controller
package disk_port_pkg;

  localparam int WORD_W          = 16;
  localparam int BYTE_W          = 8;
  localparam int LEN_W           = 16;
  localparam int FIFO_DEPTH      = 16;
  localparam int BYTES_PER_WORD  = 2;
  localparam int MIN_BURST_BYTES = 2;
  localparam int CSEL_SYNC_N     = 3;

  localparam logic [WORD_W-1:0] BUS_RELEASED = 16'hffff;
  localparam logic [BYTE_W-1:0] BYTE_ZERO    = 8'h00;

  // host register map, word indices on the plain register port
  localparam int                REG_AW     = 3;
  localparam logic [REG_AW-1:0] REG_CTRL   = 3'h0;
  localparam logic [REG_AW-1:0] REG_LEN    = 3'h1;
  localparam logic [REG_AW-1:0] REG_BURST  = 3'h2;
  localparam logic [REG_AW-1:0] REG_STATUS = 3'h3;
  localparam logic [REG_AW-1:0] REG_DATA   = 3'h4;

  // control register bits
  localparam int CTRL_START_PIO = 0;
  localparam int CTRL_START_DMA = 1;
  localparam int CTRL_NARROW    = 2;
  localparam int CTRL_DEV_SEL   = 3;

  // status register bits
  localparam int ST_BUSY  = 0;
  localparam int ST_DONE  = 1;
  localparam int ST_BSY   = 2;
  localparam int ST_DRQ   = 3;
  localparam int ST_DMARQ = 4;
  localparam int ST_W     = 5;

  localparam logic [LEN_W-1:0] LEN_RESET   = 16'h0000;
  localparam logic [LEN_W-1:0] BURST_RESET = 16'h0200;

  typedef enum logic [2:0]
  {
    H_IDLE    = 3'b000,
    H_WAIT    = 3'b001,
    H_ACK     = 3'b010,
    H_STROBE  = 3'b011,
    H_CAPTURE = 3'b100
  } host_state_t;

endpackage : disk_port_pkg

// File: hdl/disk_bus_if.sv
// Purpose: the parallel disk bus between host controller and device end
// Assumes: both parties share i_clk; data lines pull high when released
// Notes:   the bus carries device-to-host data only
`timescale 1ns/1ns
interface disk_bus_if;
  import disk_port_pkg::*;

  logic [WORD_W-1:0] dd_dev;
  logic              dd_dev_oe_n;
  logic [WORD_W-1:0] dd;
  logic              rd_stb;
  logic              dev_sel;
  logic              bsy;
  logic              drq;
  logic              dmarq;
  logic              dmack_n;

  // released lines float to the pull-up level
  assign dd = dd_dev_oe_n ? BUS_RELEASED : dd_dev;

  modport host_end
  (
    input  dd,
    input  bsy,
    input  drq,
    input  dmarq,
    output rd_stb,
    output dev_sel,
    output dmack_n
  );

  modport dev_end
  (
    output dd_dev,
    output dd_dev_oe_n,
    output bsy,
    output drq,
    output dmarq,
    input  rd_stb,
    input  dev_sel,
    input  dmack_n
  );
endinterface : disk_bus_if

// File: hdl/disk_dev_end.sv
// Purpose: device end: packs outgoing bytes into bus words and serves
//          programmed-I/O and DMA reads from a word FIFO
// Assumes: one clock i_clk, synchronous active-low reset i_resetn
// Notes:   cable select arrives from a pin and is synchronised
//
// How it works
// - pio words move only when not busy and requesting
// - pio is 16 bits; 8-bit pio optional
// - each data-request block restarts byte numbering
// - dma moves only after request then acknowledge
// - dma always uses the full 16-bit bus
// - each acknowledge period is one burst
// - a dma burst holds at least one word
// - bytes numbered 0 to n-1, byte 0 first
// - even byte on low lane, odd on high
// - 8-bit pio: one byte on low lane, ascending
// - one host, one or two devices, ids 0/1
// - id from jumper or from cable select level
`timescale 1ns/1ns

module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             i_clk,
  input  wire logic             i_resetn,
  input  wire logic [WIDTH-1:0] i_in_data,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  output logic      [WIDTH-1:0] o_out_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  input  wire logic             i_flush
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = i_in_valid && o_in_ready;
  wire              pop  = o_out_valid && i_out_ready;
  wire  [AW-1:0]    last = AW'(DEPTH - 1);

  assign o_in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign o_out_valid = (count_reg != '0);
  assign o_out_data  = mem[rd_ptr_reg];

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= i_in_data;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || i_flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == last) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == last) ? '0 : rd_ptr_reg + 1'b1;
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : word_fifo

module disk_dev_end
  import disk_port_pkg::*;
#(
  parameter bit NARROW_PIO_OK = 1'b1,
  parameter int DEPTH         = FIFO_DEPTH
) (
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  disk_bus_if.dev_end            bus,
  input  wire logic [BYTE_W-1:0] i_tx_byte,
  input  wire logic              i_tx_valid,
  output logic                   o_tx_ready,
  input  wire logic              i_start,
  input  wire logic              i_dma,
  input  wire logic              i_narrow,
  input  wire logic [LEN_W-1:0]  i_len,
  input  wire logic              i_jumper_en,
  input  wire logic              i_jumper_dev,
  input  wire logic              i_csel,
  output logic                   o_dev_id,
  output logic                   o_active,
  output logic                   o_done,
  output logic                   o_burst_end
);
  logic [CSEL_SYNC_N-1:0] csel_sync_reg;
  logic                   csel_level_reg;
  logic                   active_reg;
  logic                   dma_reg;
  logic                   narrow_reg;
  logic [LEN_W-1:0]       len_reg;
  logic [LEN_W-1:0]       cnt_reg;
  logic                   half_reg;
  logic [BYTE_W-1:0]      lo_byte_reg;
  logic [WORD_W-1:0]      dd_reg;
  logic                   dd_oe_n_reg;
  logic                   dmack_n_prev_reg;
  logic                   done_reg;
  logic                   burst_end_reg;

  logic [WORD_W-1:0]      fifo_in_data;
  logic                   fifo_in_valid;
  logic                   fifo_in_ready;
  logic [WORD_W-1:0]      fifo_out_data;
  logic                   fifo_out_valid;

  // a change on cable select counts once the 2nd and 3rd stages agree
  wire csel_agree = (csel_sync_reg[1] == csel_sync_reg[2]);

  assign o_dev_id = i_jumper_en ? i_jumper_dev : csel_level_reg;
  wire selected   = (bus.dev_sel == o_dev_id);

  // 8-bit transfers only in pio and only where the part allows it
  wire narrow_req = NARROW_PIO_OK && i_narrow && !i_dma;
  wire byte_mode  = narrow_reg;
  wire [LEN_W-1:0] step = byte_mode ? LEN_W'(1) : LEN_W'(BYTES_PER_WORD);
  // an odd 16-bit length drops its last byte rather than pad the lane
  wire [LEN_W-1:0] len_even = {i_len[LEN_W-1:1], 1'b0};
  wire [LEN_W-1:0] len_eff  = narrow_req ? i_len : len_even;

  // byte 0 lands on the low lane, its successor on the high lane
  assign fifo_in_data  = byte_mode ? {BYTE_ZERO, i_tx_byte}
                                   : {i_tx_byte, lo_byte_reg};
  assign fifo_in_valid = i_tx_valid && (byte_mode || half_reg);
  assign o_tx_ready    = (byte_mode || half_reg) ? fifo_in_ready : 1'b1;
  wire   lo_take       = i_tx_valid && !byte_mode && !half_reg;

  wire data_ready = active_reg && fifo_out_valid;
  assign bus.bsy   = active_reg && !fifo_out_valid;
  assign bus.drq   = data_ready && !dma_reg && selected;
  assign bus.dmarq = data_ready && dma_reg && selected;

  wire pio_take = !dma_reg && !bus.bsy && bus.drq;
  wire dma_take = dma_reg && bus.dmarq && !bus.dmack_n;
  wire pop      = bus.rd_stb && (pio_take || dma_take);
  wire [LEN_W-1:0] cnt_next = cnt_reg + step;
  wire last_one = (cnt_next >= len_reg);

  assign bus.dd_dev      = dd_reg;
  assign bus.dd_dev_oe_n = dd_oe_n_reg;
  assign o_active        = active_reg;
  assign o_done          = done_reg;
  assign o_burst_end     = burst_end_reg;

  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) tx_fifo (
    .i_clk       (i_clk),
    .i_resetn    (i_resetn),
    .i_in_data   (fifo_in_data),
    .i_in_valid  (fifo_in_valid),
    .o_in_ready  (fifo_in_ready),
    .o_out_data  (fifo_out_data),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (pop),
    .i_flush     (i_start)
  );

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      csel_sync_reg  <= '0;
      csel_level_reg <= 1'b0;
    end
    else
    begin
      csel_sync_reg <= {csel_sync_reg[CSEL_SYNC_N-2:0], i_csel};
      if (csel_agree)
        csel_level_reg <= csel_sync_reg[2];
    end
  end

  // block framing: a new start flushes the fifo and restarts numbering
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      active_reg <= 1'b0;
      dma_reg    <= 1'b0;
      narrow_reg <= 1'b0;
      len_reg    <= LEN_RESET;
      cnt_reg    <= LEN_RESET;
      done_reg   <= 1'b0;
    end
    else if (i_start)
    begin
      active_reg <= (len_eff != LEN_RESET);
      dma_reg    <= i_dma;
      narrow_reg <= narrow_req;
      len_reg    <= len_eff;
      cnt_reg    <= LEN_RESET;
      done_reg   <= 1'b0;
    end
    else
    begin
      done_reg <= pop && last_one;
      if (pop)
      begin
        cnt_reg <= cnt_next;
        if (last_one)
          active_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn || i_start)
    begin
      half_reg    <= 1'b0;
      lo_byte_reg <= BYTE_ZERO;
    end
    else if (lo_take)
    begin
      half_reg    <= 1'b1;
      lo_byte_reg <= i_tx_byte;
    end
    else if (fifo_in_valid && fifo_in_ready)
      half_reg <= 1'b0;
  end

  // the word is driven for exactly the cycle after the read strobe
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      dd_reg           <= BUS_RELEASED;
      dd_oe_n_reg      <= 1'b1;
      dmack_n_prev_reg <= 1'b1;
      burst_end_reg    <= 1'b0;
    end
    else
    begin
      dd_oe_n_reg      <= !pop;
      dmack_n_prev_reg <= bus.dmack_n;
      burst_end_reg    <= !dmack_n_prev_reg && bus.dmack_n;
      if (pop)
        dd_reg <= fifo_out_data;
    end
  end
endmodule : disk_dev_end

// File: hdl/disk_host_end.sv
// Purpose: host controller: runs pio or dma reads on the disk bus
//          under control of a small register file
// Assumes: one clock i_clk, synchronous active-low reset i_resetn
// Notes:   bus signals come from logic on the same clock, unsynchronised
`timescale 1ns/1ns
module disk_host_end
  import disk_port_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  disk_bus_if.host_end           bus,
  input  wire logic [REG_AW-1:0] i_addr,
  input  wire logic [31:0]       i_wdata,
  input  wire logic              i_wr,
  input  wire logic              i_rd,
  output logic      [31:0]       o_rdata,
  output logic      [WORD_W-1:0] o_data,
  output logic                   o_data_valid,
  output logic                   o_data_narrow
);
  host_state_t       state_reg;
  host_state_t       state_next;
  logic              dma_reg;
  logic              narrow_reg;
  logic              dev_sel_reg;
  logic              done_reg;
  logic [LEN_W-1:0]  len_reg;
  logic [LEN_W-1:0]  burst_lim_reg;
  logic [LEN_W-1:0]  cnt_reg;
  logic [LEN_W-1:0]  burst_cnt_reg;
  logic [WORD_W-1:0] data_reg;
  logic              data_valid_reg;
  logic [31:0]       rdata_reg;

  wire ctrl_wr   = i_wr && (i_addr == REG_CTRL);
  wire start_pio = ctrl_wr && i_wdata[CTRL_START_PIO];
  wire start_dma = ctrl_wr && i_wdata[CTRL_START_DMA] && !start_pio;
  wire start     = (start_pio || start_dma) && (state_reg == H_IDLE);
  wire narrow_wr = start_pio && i_wdata[CTRL_NARROW];
  wire [LEN_W-1:0] step = narrow_reg ? LEN_W'(1) : LEN_W'(BYTES_PER_WORD);
  wire [LEN_W-1:0] len_req = i_wdata[LEN_W-1:0];
  wire [LEN_W-1:0] burst_req = (len_req < LEN_W'(MIN_BURST_BYTES))
                               ? LEN_W'(MIN_BURST_BYTES) : len_req;
  wire block_end = (cnt_reg >= len_reg);
  // a burst limit is counted in whole words
  wire burst_full = (burst_cnt_reg >= {burst_lim_reg[LEN_W-1:1], 1'b0});
  wire in_ack    = (state_reg == H_ACK) || (state_reg == H_STROBE)
                   || (state_reg == H_CAPTURE);

  assign bus.rd_stb  = (state_reg == H_STROBE);
  assign bus.dev_sel = dev_sel_reg;
  assign bus.dmack_n = !(dma_reg && in_ack);
  assign o_data        = data_reg;
  assign o_data_valid  = data_valid_reg;
  assign o_data_narrow = narrow_reg;
  assign o_rdata       = rdata_reg;

  wire [ST_W-1:0] status = {bus.dmarq, bus.drq, bus.bsy, done_reg,
                            (state_reg != H_IDLE)};
  wire [31:0] rd_mux =
      (i_addr == REG_CTRL)   ? {28'h0000000, dev_sel_reg, narrow_reg, 2'b00}
    : (i_addr == REG_LEN)    ? {16'h0000, len_reg}
    : (i_addr == REG_BURST)  ? {16'h0000, burst_lim_reg}
    : (i_addr == REG_STATUS) ? {27'h0, status}
    : (i_addr == REG_DATA)   ? {16'h0000, data_reg}
    : 32'h00000000;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      H_IDLE:
        if (start)
          state_next = H_WAIT;
      H_WAIT:
        if (block_end)
          state_next = H_IDLE;
        else if (!dma_reg && !bus.bsy && bus.drq)
          state_next = H_STROBE;
        else if (dma_reg && bus.dmarq)
          state_next = H_ACK;
      H_ACK:
        // ending the burst negates acknowledge for at least one cycle
        if (block_end || burst_full || !bus.dmarq)
          state_next = H_WAIT;
        else
          state_next = H_STROBE;
      H_STROBE:
        state_next = H_CAPTURE;
      H_CAPTURE:
        state_next = dma_reg ? H_ACK : H_WAIT;
      default:
        state_next = H_IDLE;
    endcase
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      state_reg <= H_IDLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      dma_reg       <= 1'b0;
      narrow_reg    <= 1'b0;
      dev_sel_reg   <= 1'b0;
      len_reg       <= LEN_RESET;
      burst_lim_reg <= BURST_RESET;
      cnt_reg       <= LEN_RESET;
    end
    else
    begin
      if (i_wr && (i_addr == REG_LEN) && (state_reg == H_IDLE))
        len_reg <= len_req;
      if (i_wr && (i_addr == REG_BURST) && (state_reg == H_IDLE))
        burst_lim_reg <= burst_req;
      if (start)
      begin
        dma_reg     <= start_dma;
        narrow_reg  <= narrow_wr;
        dev_sel_reg <= i_wdata[CTRL_DEV_SEL];
        cnt_reg     <= LEN_RESET;
        if (!narrow_wr)
          len_reg <= {len_reg[LEN_W-1:1], 1'b0};
      end
      else if (state_reg == H_CAPTURE)
        cnt_reg <= cnt_reg + step;
    end
  end

  // data captured in the cycle after the strobe, lanes kept as on the bus except that narrow mode zeroes the high lane
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      burst_cnt_reg  <= LEN_RESET;
      data_reg       <= '0;
      data_valid_reg <= 1'b0;
      done_reg       <= 1'b0;
      rdata_reg      <= 32'h00000000;
    end
    else
    begin
      data_valid_reg <= (state_reg == H_CAPTURE);
      if (state_reg == H_CAPTURE)
      begin
        data_reg      <= narrow_reg ? {BYTE_ZERO, bus.dd[BYTE_W-1:0]}
                                    : bus.dd;
        burst_cnt_reg <= burst_cnt_reg + step;
      end
      else if (!in_ack)
        burst_cnt_reg <= LEN_RESET;
      // completion wins over a clearing start in the same cycle
      if ((state_reg == H_WAIT) && block_end)
        done_reg <= 1'b1;
      else if (start)
        done_reg <= 1'b0;
      rdata_reg <= i_rd ? rd_mux : 32'h00000000;
    end
  end
endmodule : disk_host_end

// File: sim/disk_port_byte_lane_order_monitor.sv
// Purpose: concurrent checks on the disk bus between host and device ends
// Assumes: one clock i_clk, synchronous active-low reset i_resetn
// Notes:   sees the interface signals only, passed in as plain inputs
`timescale 1ns/1ns
module disk_port_byte_lane_order_monitor
  import disk_port_pkg::*;
(
  input wire logic              i_clk,
  input wire logic              i_resetn,
  input wire logic [WORD_W-1:0] i_dd_dev,
  input wire logic              i_dd_dev_oe_n,
  input wire logic [WORD_W-1:0] i_dd,
  input wire logic              i_rd_stb,
  input wire logic              i_dev_sel,
  input wire logic              i_bsy,
  input wire logic              i_drq,
  input wire logic              i_dmarq,
  input wire logic              i_dmack_n
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  AST_PIO_GATE: assert property (i_rd_stb && i_dmack_n |-> !$past(i_bsy) && $past(i_drq))
    else $error("pio strobe without ready status");
  AST_ACK_AFTER_REQ: assert property ($fell(i_dmack_n) |-> $past(i_dmarq))
    else $error("acknowledge without dma request");
  AST_DMA_STROBE: assert property (i_rd_stb && !i_dmack_n |-> !$past(i_dmack_n))
    else $error("dma strobe in the acknowledge cycle");
  AST_BURST_MIN: assert property ($fell(i_dmack_n) |-> ##1 i_rd_stb)
    else $error("burst without a word");
  AST_ACK_HOLD: assert property (i_rd_stb && !i_dmack_n |=> !i_dmack_n [*2])
    else $error("acknowledge dropped inside a word");
  AST_STROBE_GAP: assert property (i_rd_stb |=> !i_rd_stb [*2])
    else $error("strobes too close");
  AST_DRIVE_ONE: assert property (!i_dd_dev_oe_n |-> $past(i_rd_stb) ##1 i_dd_dev_oe_n)
    else $error("data drive not one cycle after strobe");
  AST_LANE_DRIVE: assert property (!i_dd_dev_oe_n |-> i_dd == i_dd_dev)
    else $error("bus does not carry device word");
  AST_BSY_EXCL: assert property (i_bsy |-> !i_drq && !i_dmarq)
    else $error("request while busy");
  AST_MODE_EXCL: assert property (!(i_drq && i_dmarq))
    else $error("pio and dma requests together");
  AST_SEL_HOLD: assert property (i_rd_stb |-> $stable(i_dev_sel))
    else $error("device select moved under a strobe");
endmodule : disk_port_byte_lane_order_monitor

// File: sim/disk_port_byte_lane_order_test.sv
// Purpose: self-checking bench for host and device ends joined by the bus
// Assumes: registers reached over the plain port, data preloaded into fifo
// Notes:   dma blocks stay within the fifo so burst counts are exact
`timescale 1ns/1ns
module disk_port_byte_lane_order_test;
  import disk_port_pkg::*;
  logic              i_clk, i_resetn, i_wr, i_rd, i_start, i_dma, i_narrow;
  logic              i_tx_valid, i_jumper_en, i_jumper_dev, i_csel;
  logic [REG_AW-1:0] i_addr;
  logic [31:0]       i_wdata, o_rdata, rd;
  logic [BYTE_W-1:0] i_tx_byte;
  logic [LEN_W-1:0]  i_len;
  logic [WORD_W-1:0] o_data;
  logic              o_data_valid, o_data_narrow, o_tx_ready, o_dev_id;
  logic              o_active, o_done, o_burst_end, ack_q;
  logic [15:0]       rx_w [0:63];
  logic [7:0]        b_a [0:63];
  int                num_errors, samples_checked, tx_idx, tx_n, rx_i, bursts, bend, dones;

  disk_bus_if bus_i ();
  disk_dev_end i_disk_dev_end (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus_i),
    .i_tx_byte(i_tx_byte), .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready),
    .i_start(i_start), .i_dma(i_dma), .i_narrow(i_narrow), .i_len(i_len),
    .i_jumper_en(i_jumper_en), .i_jumper_dev(i_jumper_dev), .i_csel(i_csel),
    .o_dev_id(o_dev_id), .o_active(o_active), .o_done(o_done), .o_burst_end(o_burst_end));
  disk_host_end i_disk_host_end (.i_clk(i_clk), .i_resetn(i_resetn), .bus(bus_i),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_data(o_data), .o_data_valid(o_data_valid), .o_data_narrow(o_data_narrow));
  disk_port_byte_lane_order_monitor i_disk_port_byte_lane_order_monitor (.i_clk(i_clk),
    .i_resetn(i_resetn), .i_dd_dev(bus_i.dd_dev), .i_dd_dev_oe_n(bus_i.dd_dev_oe_n),
    .i_dd(bus_i.dd), .i_rd_stb(bus_i.rd_stb), .i_dev_sel(bus_i.dev_sel),
    .i_bsy(bus_i.bsy), .i_drq(bus_i.drq), .i_dmarq(bus_i.dmarq),
    .i_dmack_n(bus_i.dmack_n));

  initial
  begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end

  // byte feeder: index moves only on an accepted byte
  always @(posedge i_clk)
  begin
    if (i_tx_valid && o_tx_ready) tx_idx = tx_idx + 1;
    i_tx_valid <= (tx_idx < tx_n);
    i_tx_byte  <= b_a[tx_idx];
  end

  always @(posedge i_clk)
  begin
    if (o_data_valid === 1'b1)
    begin
      rx_w[rx_i] = o_data;
      rx_i = rx_i + 1;
    end
    if (ack_q && (bus_i.dmack_n === 1'b0)) bursts = bursts + 1;
    if (o_burst_end === 1'b1) bend = bend + 1;
    if (o_done === 1'b1) dones = dones + 1;
    ack_q = bus_i.dmack_n;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_wr(input logic [REG_AW-1:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(input logic [REG_AW-1:0] a, output logic [31:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
  endtask : reg_rd

  function automatic logic [15:0] exp_word(input bit nar, input int k);
    exp_word = nar ? {8'h00, b_a[k]} : {b_a[2*k+1], b_a[2*k]};
  endfunction : exp_word

  task automatic run_block(input bit dma, input bit nar, input int len, input int burst);
    int          words, bb, st_i;
    bit          en;
    logic [31:0] st;
    en = nar && !dma;
    for (int i = 0; i < 64; i++) b_a[i] = $urandom;
    reg_wr(REG_BURST, burst);
    reg_wr(REG_LEN, len);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_dma <= dma;
    i_narrow <= nar;
    i_len <= len[15:0];
    @(posedge i_clk);
    i_start <= 1'b0;
    @(negedge i_clk);
    {tx_idx, rx_i, bursts, bend, dones} = '0;
    tx_n = en ? len : (len / 2) * 2;
    for (st_i = 0; st_i < 100 && tx_idx < tx_n; st_i++) @(posedge i_clk);
    if (tx_n > 34) check("tx ready when full", {31'h0, o_tx_ready}, 32'h0);
    check("device active", {31'h0, o_active}, 32'h1);
    reg_wr(REG_CTRL, {28'h0, i_jumper_dev, nar, dma, !dma});
    st = 32'h0;
    for (st_i = 0; st_i < 3000 && st[ST_DONE] !== 1'b1; st_i++) reg_rd(REG_STATUS, st);
    repeat (4) @(posedge i_clk);
    words = en ? len : len / 2;
    check("done", {31'h0, st[ST_DONE]}, 32'h1);
    check("word count", rx_i, words);
    for (int k = 0; k < words; k++) check("word", rx_w[k], exp_word(en, k));
    check("narrow mode", {31'h0, o_data_narrow}, {31'h0, en});
    check("device done", dones, 1);
    check("device idle", {31'h0, o_active}, 32'h0);
    reg_rd(REG_CTRL, st);
    check("ctrl readback", st, {28'h0, i_jumper_dev, en, 2'b00});
    reg_rd(REG_DATA, st);
    check("last word", st, {16'h0, exp_word(en, words - 1)});
    if (dma)
    begin
      bb = (burst < 2) ? 2 : (burst / 2) * 2;
      check("bursts", bursts, (words + bb / 2 - 1) / (bb / 2));
      check("burst ends", bend, bursts);
    end
    @(negedge i_clk);
    tx_n = 0;
    $display("test block dma=%0d narrow=%0d len=%0d done", dma, nar, len);
  endtask : run_block

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial
  begin
    #300000;
    num_errors++;
    print_verdict();
  end

  initial
  begin
    {i_resetn, i_wr, i_rd, i_start, i_dma, i_narrow, i_jumper_dev, i_csel} = '0;
    {i_addr, i_wdata, i_len, tx_idx, tx_n, rx_i, bursts, bend} = '0;
    {num_errors, samples_checked} = '0;
    i_jumper_en = 1'b1;
    ack_q = 1'b1;
    void'($urandom(32'haddf676d));
    repeat (20) @(posedge i_clk);
    i_resetn <= 1'b1;
    reg_rd(REG_BURST, rd);
    check("burst reset", rd, {16'h0, BURST_RESET});
    reg_rd(REG_LEN, rd);
    check("len reset", rd, {16'h0, LEN_RESET});
    reg_rd(3'h7, rd);
    check("unmapped read", rd, 32'h0);
    check("jumper id 0", {31'h0, o_dev_id}, 32'h0);
    @(posedge i_clk);
    i_jumper_en <= 1'b0;
    i_csel <= 1'b1;
    repeat (6) @(posedge i_clk);
    check("cable select id 1", {31'h0, o_dev_id}, 32'h1);
    i_csel <= 1'b0;
    i_jumper_en <= 1'b1;
    i_jumper_dev <= 1'b1;
    repeat (2) @(posedge i_clk);
    check("jumper id 1", {31'h0, o_dev_id}, 32'h1);
    i_jumper_dev <= 1'b0;
    repeat (6) @(posedge i_clk);
    $display("test device id done");
    // corner cases: minimum burst, forced burst limit, odd and narrow lengths, full fifo
    run_block(1'b1, 1'b0, 2, 2);
    run_block(1'b1, 1'b0, 16, 1);
    run_block(1'b1, 1'b1, 12, 5);
    run_block(1'b0, 1'b0, 7, 0);
    run_block(1'b0, 1'b1, 5, 0);
    run_block(1'b0, 1'b0, 40, 0);
    repeat (8)
    begin
      i_jumper_dev <= 1'($urandom_range(1, 0));
      run_block($urandom_range(1, 0), $urandom_range(1, 0),
                $urandom_range(16, 1) * 2, $urandom_range(12, 0));
    end
    print_verdict();
  end
endmodule : disk_port_byte_lane_order_test
